// [core/frx_flag_bank.sv]
`timescale 1ns/1ps
module frx_flag_bank
   import frx_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // events and clears
   input wire frx_pkg::frx_byte_t set,
   input wire logic clr_all,
   input wire frx_pkg::frx_byte_t clr_mask,
   // sticky flags
   output frx_pkg::frx_byte_t flags
);
   // set after clear, so an event in the clearing cycle survives
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flags <= RST_FLAGS;
      end else if (clr_all) begin
         flags <= set;
      end else begin
         flags <= (flags & ~clr_mask) | set;
      end
   end
endmodule

// [core/frx_pkg.sv]
package frx_pkg;

   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_ALM_EN = 6'h03;
   localparam logic [5:0] IDX_EVT_ST = 6'h04;
   localparam logic [5:0] IDX_EVT_EN = 6'h05;
   localparam logic [5:0] IDX_ALM_ST = 6'h08;
   localparam logic [5:0] IDX_CFG = 6'h09;

   // event status / enable bit positions
   localparam int EVT_CAS_MF = 7;
   localparam int EVT_NAT = 6;
   localparam int EVT_SIG = 5;
   localparam int EVT_FALIGN = 4;
   localparam int EVT_INFRAME = 3;
   localparam int EVT_MIMIC = 2;
   localparam int EVT_SYNC = 1;
   localparam int EVT_FERR = 0;

   // alarm enable / alarm status bit positions
   localparam int ALM_BPV = 3;
   localparam int ALM_RED = 2;
   localparam int ALM_AIS = 1;
   localparam int ALM_YEL = 0;

   // configuration bit positions
   localparam int CFG_E1 = 0;

   // reset values, writable masks and the mask of used alarm status bits
   localparam logic [7:0] RST_ALM_EN = 8'h00;
   localparam logic [7:0] RST_EVT_EN = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] ALM_EN_RW = 8'h3f;
   localparam logic [7:0] ALM_ST_USED = 8'h0f;
   localparam logic [7:0] CFG_RW = 8'h01;

   typedef logic [7:0] frx_byte_t;

   // word index from a wishbone byte address
   function automatic logic [5:0] frx_word_idx(input logic [7:0] adr);
      return adr[7:2];
   endfunction

   // true when an access hits the given register
   function automatic logic frx_hit(input logic stb, input logic [5:0] idx,
                                    input logic [5:0] target);
      return stb && (idx == target);
   endfunction

endpackage

// [core/frx_reg_if.sv]
`timescale 1ns/1ps
interface frx_reg_if;
   import frx_pkg::*;
   logic rd;
   logic wr;
   logic [5:0] idx;
   frx_byte_t wdat;
   frx_byte_t rdat;
   modport bus (output rd, output wr, output idx, output wdat, input rdat);
   modport core (input rd, input wr, input idx, input wdat, output rdat);
endinterface

// [core/frx_rx_event_flags.sv]
`timescale 1ns/1ps
module frx_rx_event_flags
   import frx_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // receive framer event pulses
   input wire logic cas_mf_change,
   input wire logic nat_bits_change,
   input wire logic sig_change,
   input wire logic falign_change,
   input wire logic inframe_change,
   input wire logic mimic_change,
   input wire logic sync_bit_err,
   input wire logic framing_err,
   // receive alarm conditions
   input wire logic bpv_pulse,
   input wire logic frame_loss,
   input wire logic ais_state,
   input wire logic yellow_state,
   // interrupt
   output logic irq
);
   import frx_pkg::*;

   frx_reg_if regs ();

   frx_byte_t alm_en;
   frx_byte_t evt_en;
   frx_byte_t cfg;
   frx_byte_t evt_set;
   frx_byte_t alm_set;
   frx_byte_t evt_flags;
   frx_byte_t alm_flags;
   frx_byte_t evt_clr;
   frx_byte_t alm_clr;
   frx_byte_t next_rdat;
   logic e1_mode;
   logic frame_loss_q;
   logic ais_q;
   logic yellow_q;
   logic evt_rd;
   logic alm_rd;
   logic next_irq;

   frx_wb_slave u_slave (
      .clk_sys(clk_sys),
      .srst(srst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .regs(regs)
   );

   assign e1_mode = cfg[CFG_E1];

   // control registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         alm_en <= RST_ALM_EN;
      end else if (frx_hit(regs.wr, regs.idx, IDX_ALM_EN)) begin
         alm_en <= regs.wdat & ALM_EN_RW;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         evt_en <= RST_EVT_EN;
      end else if (frx_hit(regs.wr, regs.idx, IDX_EVT_EN)) begin
         evt_en <= regs.wdat;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg <= RST_CFG;
      end else if (frx_hit(regs.wr, regs.idx, IDX_CFG)) begin
         cfg <= regs.wdat & CFG_RW;
      end
   end

   // previous alarm levels for change detection
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         frame_loss_q <= 1'b0;
         ais_q <= 1'b0;
         yellow_q <= 1'b0;
      end else begin
         frame_loss_q <= frame_loss;
         ais_q <= ais_state;
         yellow_q <= yellow_state;
      end
   end

   // event sources; the E1-only bits are masked in T1 so they stay clear
   always_comb begin
      evt_set = 8'h00;
      evt_set[EVT_CAS_MF] = cas_mf_change && e1_mode;
      evt_set[EVT_NAT] = nat_bits_change && e1_mode;
      evt_set[EVT_SIG] = sig_change;
      evt_set[EVT_FALIGN] = falign_change;
      evt_set[EVT_INFRAME] = inframe_change;
      evt_set[EVT_MIMIC] = mimic_change;
      evt_set[EVT_SYNC] = sync_bit_err;
      evt_set[EVT_FERR] = framing_err;
   end

   // alarm events: a violation, the onset of frame loss, AIS and yellow changes
   always_comb begin
      alm_set = 8'h00;
      alm_set[ALM_BPV] = bpv_pulse;
      alm_set[ALM_RED] = frame_loss && !frame_loss_q;
      alm_set[ALM_AIS] = ais_state ^ ais_q;
      alm_set[ALM_YEL] = yellow_state ^ yellow_q;
   end

   // clears: a read empties the register, a write of ones clears those bits
   assign evt_rd = frx_hit(regs.rd, regs.idx, IDX_EVT_ST);
   assign alm_rd = frx_hit(regs.rd, regs.idx, IDX_ALM_ST);
   assign evt_clr = frx_hit(regs.wr, regs.idx, IDX_EVT_ST) ? regs.wdat : 8'h00;
   assign alm_clr = frx_hit(regs.wr, regs.idx, IDX_ALM_ST) ? regs.wdat : 8'h00;

   frx_flag_bank u_evt_flags (
      .clk_sys(clk_sys),
      .srst(srst),
      .set(evt_set),
      .clr_all(evt_rd),
      .clr_mask(evt_clr),
      .flags(evt_flags)
   );

   frx_flag_bank u_alm_flags (
      .clk_sys(clk_sys),
      .srst(srst),
      .set(alm_set),
      .clr_all(alm_rd),
      .clr_mask(alm_clr),
      .flags(alm_flags)
   );

   // read data; unmapped indices and reserved bits read as zero, except alarm enable bits 5:4, which read back as written
   always_comb begin
      next_rdat = 8'h00;
      if (regs.idx == IDX_ALM_EN) begin
         next_rdat = alm_en;
      end else if (regs.idx == IDX_EVT_ST) begin
         next_rdat = evt_flags;
      end else if (regs.idx == IDX_EVT_EN) begin
         next_rdat = evt_en;
      end else if (regs.idx == IDX_ALM_ST) begin
         next_rdat = alm_flags & ALM_ST_USED;
      end else if (regs.idx == IDX_CFG) begin
         next_rdat = cfg;
      end
   end
   assign regs.rdat = next_rdat;

   // registered level; one cycle late but glitch free at the pin
   assign next_irq = (|(evt_flags & evt_en)) ||
                     (|(alm_flags & alm_en & ALM_ST_USED));

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // checks
   property p_bpv_irq;
      @(posedge clk_sys) disable iff (srst)
         (bpv_pulse && alm_en[ALM_BPV] && !frx_hit(regs.wr, regs.idx, IDX_ALM_EN))
         |-> ##2 irq;
   endproperty
   a_bpv_irq: assert property (p_bpv_irq) else $error("bpv did not raise irq");

   property p_red_flag;
      @(posedge clk_sys) disable iff (srst)
         (frame_loss && !frame_loss_q) |=> alm_flags[ALM_RED];
   endproperty
   a_red_flag: assert property (p_red_flag) else $error("frame loss not flagged");

   property p_ais_flag;
      @(posedge clk_sys) disable iff (srst)
         (ais_state != ais_q) |=> alm_flags[ALM_AIS];
   endproperty
   a_ais_flag: assert property (p_ais_flag) else $error("ais change not flagged");

   property p_yel_flag;
      @(posedge clk_sys) disable iff (srst)
         (yellow_state != yellow_q) |=> alm_flags[ALM_YEL];
   endproperty
   a_yel_flag: assert property (p_yel_flag) else $error("yellow change not flagged");

   property p_evt_reset;
      @(posedge clk_sys) srst |=> (evt_flags == 8'h00 && evt_en == 8'h00 && !irq);
   endproperty
   a_evt_reset: assert property (p_evt_reset) else $error("reset values wrong");

   property p_t1_cas;
      @(posedge clk_sys) disable iff (srst)
         (!e1_mode && !evt_flags[EVT_CAS_MF]) |=> !evt_flags[EVT_CAS_MF];
   endproperty
   a_t1_cas: assert property (p_t1_cas) else $error("cas flag set in t1");

   property p_e1_nat;
      @(posedge clk_sys) disable iff (srst)
         (e1_mode && nat_bits_change) |=> evt_flags[EVT_NAT];
   endproperty
   a_e1_nat: assert property (p_e1_nat) else $error("national bit change lost");

   property p_t1_nat;
      @(posedge clk_sys) disable iff (srst)
         (!e1_mode && !evt_flags[EVT_NAT]) |=> !evt_flags[EVT_NAT];
   endproperty
   a_t1_nat: assert property (p_t1_nat) else $error("national flag set in t1");

   property p_set_sticky;
      @(posedge clk_sys) disable iff (srst)
         (evt_set != 8'h00) |=> ((evt_flags & $past(evt_set)) == $past(evt_set));
   endproperty
   a_set_sticky: assert property (p_set_sticky) else $error("event flag not set");

   property p_quiet_hold;
      @(posedge clk_sys) disable iff (srst)
         (evt_set == 8'h00 && !regs.rd && !regs.wr) |=> $stable(evt_flags);
   endproperty
   a_quiet_hold: assert property (p_quiet_hold) else $error("flag moved alone");

   property p_rd_clear;
      @(posedge clk_sys) disable iff (srst)
         (evt_rd && evt_set == 8'h00) |=> (evt_flags == 8'h00);
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear");

   property p_alm_rd_clear;
      @(posedge clk_sys) disable iff (srst)
         (alm_rd && alm_set == 8'h00) |=> (alm_flags == 8'h00);
   endproperty
   a_alm_rd_clear: assert property (p_alm_rd_clear) else $error("alarm not cleared");

   property p_en_write;
      @(posedge clk_sys) disable iff (srst)
         frx_hit(regs.wr, regs.idx, IDX_EVT_EN) |=> (evt_en == $past(regs.wdat));
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   property p_irq_on;
      @(posedge clk_sys) disable iff (srst)
         (|(evt_flags & evt_en)) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");

   property p_irq_off;
      @(posedge clk_sys) disable iff (srst)
         ((evt_en == 8'h00) && (alm_en[3:0] == 4'h0)) [*2] |-> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

   property p_ack_once;
      @(posedge clk_sys) disable iff (srst)
         (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack timing wrong");

   c_rd_clear: cover property (@(posedge clk_sys) disable iff (srst)
      evt_rd && evt_flags != 8'h00);
   c_set_wins: cover property (@(posedge clk_sys) disable iff (srst)
      evt_rd && evt_set != 8'h00);
   c_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));
   c_w1c: cover property (@(posedge clk_sys) disable iff (srst)
      evt_clr != 8'h00 && evt_flags != 8'h00);
endmodule

// [core/frx_wb_slave.sv]
`timescale 1ns/1ps
module frx_wb_slave
   import frx_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // register strobes toward the core
   frx_reg_if.bus regs
);
   logic req;

   // one strobe per request: ack blocks a second strobe in the ack cycle
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign regs.rd = req && !wb_we_i;
   assign regs.wr = req && wb_we_i && wb_sel_i[0];
   assign regs.idx = frx_word_idx(wb_adr_i);
   assign regs.wdat = wb_dat_i[7:0];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (regs.rd) begin
         wb_dat_o <= {24'h00_0000, regs.rdat};
      end
   end
endmodule

// [tb/frx_host_model.sv]
`timescale 1ns/1ps
module frx_host_model (
   // clock
   input wire logic clk_sys,
   // wishbone master side
   output logic wb_cyc,
   output logic wb_stb,
   output logic wb_we,
   output logic [7:0] wb_adr,
   output logic [3:0] wb_sel,
   output logic [31:0] wb_dat_w,
   input wire logic wb_ack
);
   initial begin
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat_w = 32'h0;
   end

   // one classic cycle held until ack is sampled; a missing ack is left to the watchdog
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hf;
      wb_dat_w <= dat;
      do begin
         @(posedge clk_sys);
      end while (wb_ack !== 1'b1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
endmodule

// [tb/tb_frx_rx_event_flags.sv]
`timescale 1ns/1ps
module tb_frx_rx_event_flags;
   logic clk_sys, srst, wb_cyc, wb_stb, wb_we, wb_ack_o, irq;
   logic [7:0] wb_adr, evt;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_o, r;
   logic bpv_pulse, frame_loss, ais_state, yellow_state;
   logic [7:0] exp_q[$];
   int err_count, checks_done, seed;

   frx_rx_event_flags u_frx_rx_event_flags (.clk_sys(clk_sys), .srst(srst),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .cas_mf_change(evt[7]), .nat_bits_change(evt[6]), .sig_change(evt[5]),
      .falign_change(evt[4]), .inframe_change(evt[3]), .mimic_change(evt[2]),
      .sync_bit_err(evt[1]), .framing_err(evt[0]), .bpv_pulse(bpv_pulse),
      .frame_loss(frame_loss), .ais_state(ais_state), .yellow_state(yellow_state), .irq(irq));

   frx_host_model u_frx_host_model (.clk_sys(clk_sys), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
      .wb_ack(wb_ack_o));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // read data is judged by the watcher when ack shows
   task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
      exp_q.push_back(exp);
      u_frx_host_model.xfer(1'b0, adr, 32'h0);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      u_frx_host_model.xfer(1'b1, adr, {24'h0, d});
   endtask

   always @(posedge clk_sys) begin
      if (wb_ack_o === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
         chk(wb_dat_o, {24'h0, exp_q.pop_front()});
      end
   end

   task automatic pulse(input logic [7:0] m);
      @(posedge clk_sys);
      evt <= m;
      @(posedge clk_sys);
      evt <= 8'h00;
   endtask

   // bit order of the alarm status: yellow, ais, frame loss, bipolar violation
   task automatic alarm(input int i);
      @(posedge clk_sys);
      case (i)
         0: yellow_state <= ~yellow_state;
         1: ais_state <= ~ais_state;
         2: frame_loss <= 1'b1;
         default: bpv_pulse <= 1'b1;
      endcase
      @(posedge clk_sys);
      frame_loss <= 1'b0;
      bpv_pulse <= 1'b0;
   endtask

   // irq lags the flag by one cycle
   task automatic irq_is(input logic v);
      @(posedge clk_sys);
      #1;
      chk({31'h0, irq}, {31'h0, v});
   endtask

   initial begin
      #200000;
      err_count++;
      results();
   end

   initial begin
      seed = 18051;
      err_count = 0;
      checks_done = 0;
      srst = 1'b1;
      evt = 8'h00;
      {bpv_pulse, frame_loss, ais_state, yellow_state} = 4'h0;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      rd(8'h10, 8'h00);
      rd(8'h14, 8'h00);
      rd(8'h0c, 8'h00);
      rd(8'h20, 8'h00);
      rd(8'h3c, 8'h00);
      // t1 mode keeps the e1-only flags clear
      pulse(8'hff);
      rd(8'h10, 8'h3f);
      irq_is(1'b0);
      rd(8'h10, 8'h00);
      wr(8'h24, 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr(8'h14, ~(8'h01 << i));
         pulse(8'h01 << i);
         irq_is(1'b0);
         wr(8'h14, 8'h01 << i);
         irq_is(1'b1);
         rd(8'h14, 8'h01 << i);
         rd(8'h10, 8'h01 << i);
         irq_is(1'b0);
      end
      // write-one clear on random flags
      r = $random(seed);
      pulse(r[7:0]);
      wr(8'h10, r[15:8]);
      rd(8'h10, r[7:0] & ~r[15:8]);
      rd(8'h10, 8'h00);
      // an event landing on the clearing edge survives the clear
      fork
         rd(8'h10, 8'h00);
         pulse(8'h10);
      join
      rd(8'h10, 8'h10);
      for (int i = 0; i < 4; i++) begin
         wr(8'h0c, 8'h00);
         alarm(i);
         irq_is(1'b0);
         rd(8'h20, 8'h01 << i);
         wr(8'h0c, 8'h01 << i);
         rd(8'h0c, 8'h01 << i);
         alarm(i);
         irq_is(1'b1);
         rd(8'h20, 8'h01 << i);
         irq_is(1'b0);
      end
      alarm(3);
      wr(8'h20, 8'h08);
      rd(8'h20, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(exp_q.size(), 32'h0);
      results();
   end
endmodule
